/* File: tb/sadc_analog_model.sv */
// ideal sample-hold, tap ladder and comparator for the converter control
// assumes tap_code and channel_sel come from sadc_top on sys_clk
`timescale 1ns/10ps

module sadc_analog_model (
    // clock
    input  wire logic        sys_clk,
    // control side
    input  wire logic [1:0]  channel_sel,
    input  wire logic        sample_hold,
    input  wire logic [9:0]  tap_code,
    output logic             comparator_high,
    // input levels as ideal codes, channel 0 in the low bits
    input  wire logic [39:0] level_codes
);
    logic [9:0] held = 10'h000;

    // held level frozen once sampling ends
    always @(posedge sys_clk) begin
        if (sample_hold)
            held <= level_codes[channel_sel*10 +: 10];
    end

    // keep bit while input at or above the tap voltage
    assign comparator_high = (held >= tap_code);
endmodule // sadc_analog_model

/* File: tb/sadc_top_sva.sv */
// port checker for the converter control block
// assumes it is bound onto sadc_top
`timescale 1ns/10ps

module sadc_top_sva
    import sadc_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    // front end and events
    input wire logic [1:0]  channel_sel,
    input wire logic        sample_hold,
    input wire logic [9:0]  tap_code,
    input wire logic        comparator_high,
    input wire logic [3:0]  timer_match,
    input wire logic        conversion_done_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic hit_res;
    logic hit_alias;
    logic ctl_wr;
    assign hit_res = reg_read && reg_addr >= SADC_RESULT_BASE
                     && reg_addr < SADC_RESULT_BASE + 32'h8;
    assign hit_alias = reg_read && reg_addr >= SADC_HIGH_BASE
                       && reg_addr < SADC_HIGH_BASE + 32'h4;
    assign ctl_wr = reg_write && (reg_addr == SADC_CTRL_A_ADDR
                                  || reg_addr == SADC_CTRL_B_ADDR);

    AST_RDATA_IDLE: assert property (
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    AST_RES_UPPER: assert property (
        hit_res |=> reg_rdata[15:10] == 6'h00)
        else $error("result word upper bits not zero");
    AST_ALIAS_UPPER: assert property (
        hit_alias |=> reg_rdata[15:8] == 8'h00)
        else $error("high byte alias upper bits not zero");
    AST_UNMAPPED: assert property (
        reg_read && reg_addr == 32'hFFFFF3F0 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    // a new enable may follow at once, so only the start gap is quiet
    AST_DISABLE: assert property (
        reg_write && reg_addr == SADC_CTRL_A_ADDR
        && !reg_wdata[SADC_A_ENABLE_BIT]
        |=> (!sample_hold && !conversion_done_irq) [*4])
        else $error("activity after disable");
    AST_START_GAP: assert property (
        ctl_wr |=> !sample_hold [*3])
        else $error("sampling within three clocks of a control write");
    // a control write may cut the window short
    AST_SAMPLE_LEN: assert property (
        $rose(sample_hold) ##0 !ctl_wr [*3]
        |-> sample_hold ##1 sample_hold ##1 !sample_hold)
        else $error("sample window not four clocks");
    AST_MSB_FIRST: assert property (
        $fell(sample_hold) && !$past(ctl_wr) |-> tap_code == 10'h200)
        else $error("first trial code is not the top bit");
    AST_CHAN_HOLD: assert property (
        sample_hold |=> $stable(channel_sel))
        else $error("channel moved while sampling");
    AST_IRQ_PULSE: assert property (
        conversion_done_irq |=> !conversion_done_irq)
        else $error("done event longer than a clock");

    COV_DONE: cover property (conversion_done_irq);
    COV_TRIG: cover property (
        timer_match != 4'h0 ##[1:200] conversion_done_irq);
    COV_RES: cover property (hit_res);
endmodule // sadc_top_sva

bind sadc_top sadc_top_sva u_sva (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .channel_sel(channel_sel),
    .sample_hold(sample_hold), .tap_code(tap_code),
    .comparator_high(comparator_high), .timer_match(timer_match),
    .conversion_done_irq(conversion_done_irq)
);

/* File: tb/tb_top.sv */
// self-checking bench for the converter control block
// assumes the ideal analog model on the front end and a 125 MHz clock
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end

module tb_top
    import sadc_pkg::*;
;
    logic sys_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, d;
    logic [1:0]  channel_sel;
    logic        sample_hold, comparator_high, conversion_done_irq;
    logic [9:0]  tap_code;
    logic [3:0]  timer_match = 4'h0;
    logic [39:0] level_codes = {10'h3FF, 10'h2AA, 10'h155, 10'h001};
    int          bad_count = 0, cmp_count = 0;
    // rows: control a, control b, slots to check, source channel per slot
    localparam logic [7:0] ROW_A [7] = '{8'h90, 8'h91, 8'h92, 8'h93,
                                         8'hB2, 8'h83, 8'hB0};
    localparam logic [7:0] ROW_B [7] = '{8'h00, 8'h07, 8'h00, 8'h03,
                                         8'h00, 8'h00, 8'h00};
    localparam logic [3:0] ROW_M [7] = '{4'h1, 4'h2, 4'h4, 4'h8,
                                         4'hF, 4'hF, 4'hF};
    localparam logic [7:0] ROW_S [7] = '{8'hE4, 8'hE4, 8'hE4, 8'hE4,
                                         8'hAA, 8'hE4, 8'h00};

    always #4 sys_clk = ~sys_clk;

    sadc_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .channel_sel(channel_sel),
        .sample_hold(sample_hold), .tap_code(tap_code),
        .comparator_high(comparator_high), .timer_match(timer_match),
        .conversion_done_irq(conversion_done_irq));
    sadc_analog_model u_analog (.sys_clk(sys_clk), .channel_sel(channel_sel),
        .sample_hold(sample_hold), .tap_code(tap_code),
        .comparator_high(comparator_high), .level_codes(level_codes));

    task automatic wr(input logic [31:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic trig(input int idx);
        @(posedge sys_clk);
        timer_match <= 4'(1 << idx);
        @(posedge sys_clk);
        timer_match <= 4'h0;
    endtask

    task automatic wait_irq();
        int n;
        for (n = 0; n < 600; n++) begin
            @(posedge sys_clk);
            #1;
            if (conversion_done_irq === 1'b1)
                return;
        end
        bad_count++;
        $display("Error at %0t: no done event", $time);
    endtask

    task automatic chk_slot(input int s, input logic [9:0] c);
        rd(SADC_RESULT_BASE + 32'(2 * s));
        `CHK(d, {6'h00, c})
        rd(SADC_HIGH_BASE + 32'(s));
        `CHK(d, {8'h00, c[9:2]})
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(SADC_CTRL_A_ADDR);
        `CHK(d, 16'h0000)
        rd(SADC_CTRL_B_ADDR);
        `CHK(d, 16'h0000)
        for (int i = 0; i < 7; i++) begin
            wr(SADC_CTRL_B_ADDR, {8'h00, ROW_B[i]});
            wr(SADC_CTRL_A_ADDR, {8'h00, ROW_A[i]});
            wait_irq();
            rd(SADC_CTRL_A_ADDR);
            `CHK(d, {8'h00, ROW_A[i]})
            for (int s = 0; s < 4; s++)
                if (ROW_M[i][s])
                    chk_slot(s,
                        level_codes[ROW_S[i][2*s +: 2]*10 +: 10]);
        end
        // status rises three clocks after the start
        wr(SADC_CTRL_A_ADDR, 16'h0091);
        rd(SADC_CTRL_A_ADDR);
        `CHK(d, 16'h0091)
        rd(SADC_CTRL_A_ADDR);
        `CHK(d, 16'h00D1)
        wait_irq();
        // restart in mid-conversion leaves slot 0 untouched
        level_codes[9:0] = 10'h0F0;
        wr(SADC_CTRL_A_ADDR, 16'h0090);
        repeat (12) @(posedge sys_clk);
        wr(SADC_CTRL_A_ADDR, 16'h0091);
        wait_irq();
        chk_slot(0, 10'h001);
        chk_slot(1, 10'h155);
        wr(SADC_CTRL_A_ADDR, 16'h0040);
        rd(SADC_CTRL_A_ADDR);
        `CHK(d, 16'h0000)
        wr(SADC_RESULT_BASE, 16'hFFFF);
        chk_slot(0, 10'h001);
        rd(32'hFFFFF3F0);
        `CHK(d, 16'h0000)
        // switch to timer trigger while enabled
        wr(SADC_CTRL_A_ADDR, 16'h0093);
        wr(SADC_CTRL_B_ADDR, 16'h0020);
        repeat (40) @(posedge sys_clk);
        rd(SADC_CTRL_A_ADDR);
        `CHK(d, 16'h0093)
        trig(0);
        wait_irq();
        chk_slot(3, 10'h3FF);
        level_codes[39:30] = 10'h2F0;
        trig(0);
        wait_irq();
        chk_slot(3, 10'h2F0);
        // four-trigger scan follows the order of the matches
        level_codes[29:0] = {10'h0AB, 10'h155, 10'h123};
        wr(SADC_CTRL_B_ADDR, 16'h0030);
        wr(SADC_CTRL_A_ADDR, 16'h0081);
        trig(2);
        repeat (30) @(posedge sys_clk);
        trig(0);
        wait_irq();
        chk_slot(2, 10'h0AB);
        chk_slot(0, 10'h123);
        report_and_stop();
    end
endmodule // tb_top

/* File: verilog/sadc_pkg.sv */
// constants for the successive-approximation converter control block
// assumes a plain register port and an external ladder, comparator and
// sample-and-hold driven by the control outputs
package sadc_pkg;

    // register addresses (byte addresses)
    localparam logic [31:0] SADC_CTRL_A_ADDR   = 32'hFFFFF380;
    localparam logic [31:0] SADC_CTRL_B_ADDR   = 32'hFFFFF382;
    localparam logic [31:0] SADC_RESULT_BASE   = 32'hFFFFF390;
    localparam logic [31:0] SADC_RESULT_STEP   = 32'h00000002;
    localparam logic [31:0] SADC_HIGH_BASE     = 32'hFFFFF3A0;
    localparam logic [31:0] SADC_HIGH_STEP     = 32'h00000001;

    // conversion_control_a fields
    localparam int SADC_A_ENABLE_BIT  = 7;
    localparam int SADC_A_STATUS_BIT  = 6;
    localparam int SADC_A_BUFFER_BIT  = 5;
    localparam int SADC_A_MODE_BIT    = 4;
    localparam int SADC_A_CHAN_LSB    = 0;

    // conversion_control_b fields
    localparam int SADC_B_TIMER_BIT   = 5;
    localparam int SADC_B_FOUR_BIT    = 4;
    localparam int SADC_B_TIME_LSB    = 0;

    // values after reset
    localparam logic [7:0]  SADC_CTRL_A_RESET = 8'h00;
    localparam logic [7:0]  SADC_CTRL_B_RESET = 8'h00;

    // widths
    localparam int SADC_RES_W = 10;
    localparam int SADC_NCH   = 4;

    // cycle counts
    localparam logic [3:0] SADC_START_CLKS  = 4'h3;
    localparam logic [3:0] SADC_SAMPLE_CLKS = 4'h4;
    localparam logic [3:0] SADC_SETTLE_BASE = 4'h1;

    // sequencer states, gray coded along idle-start-sample-convert-store
    typedef enum logic [2:0] {
        SADC_IDLE    = 3'h0,
        SADC_START   = 3'h1,
        SADC_SAMPLE  = 3'h3,
        SADC_CONVERT = 3'h2,
        SADC_STORE   = 3'h6,
        SADC_WAIT    = 3'h4
    } sadc_state_e;

endpackage

/* File: verilog/sadc_top.sv */
// control and result registers of a four-channel 10-bit APPROXIMATION_REGISTER converter
// assumes comparator_high is valid and synchronous to sys_clk, and that
// timer_match carries one-cycle compare-match pulses
//
// Functional notes
// R1: approximation register is 10 bits, decided MSB first from comparator.
// R2: after the LSB is decided the value goes to the assigned result slot.
// R3: result slots have no reset; contents undefined until a conversion ends.
// R4: controller picks channel, times sample-and-hold and handles triggers.
// R5: control A is 8 bits; writing it aborts and restarts conversion.
// R6: bit 6 of control A is read-only status; 1 while converting.
// R7: bit 7 of control A enables conversion.
// R8: status bit goes to 1 three clocks after a conversion starts.
// R9: bit 5 of control A picks 1-buffer or 4-buffer storage.
// R10: bit 4 of control A picks scan (0) or select (1) mode.
// R11: channel field picks one channel, or scan range 0 up to field.
// R12: timer 4-trigger scan: field counts triggers; order follows matches.
// R13: timer mode enable enters trigger wait; cleared only by write or reset.
// R14: internal trigger mode: writing enable 1 starts the conversion.
// R15: switch to timer trigger with enable set enters trigger wait at once.
// R16: control B sets time and trigger; writing it aborts and restarts.
// R17: four read-only results; 16-bit word read and upper-byte alias read.
// R18: result word holds 10 value bits; upper six read as zero.
// R19: except 4-buffer mode, channel n result goes to result slot n.
// R20: code is integer of input over reference times 1024 plus one half.
// R21: done pulse after the configured number of conversions.
// R22: 4-buffer select converts one channel four times into slots 0 to 3.
// R23: scan converts channels from 0 upward into matching slots.
// R24: timer mode: each trigger starts one conversion, then back to wait.
// R25: each step drives trial code, waits settling, then samples comparator.
// R26: 1-buffer select stops after each conversion until enable written again.
`timescale 1ns/10ps

module sadc_top
    import sadc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // analog front end
    output logic      [1:0]  channel_sel,
    output logic             sample_hold,
    output logic      [9:0]  tap_code,
    input  wire logic        comparator_high,
    // trigger timer compare matches
    input  wire logic [3:0]  timer_match,
    // conversion end event
    output logic             conversion_done_irq
);

    // returns {hit, index} for a group of four registers at base/step
    function automatic logic [2:0] slot_hit(
        input logic [31:0] addr,
        input logic [31:0] base,
        input logic [31:0] step
    );
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < SADC_NCH; i++) begin
            if (addr == base + step * i) begin
                r = {1'b1, i[1:0]};
            end
        end
        return r;
    endfunction

    // control fields
    logic                  enable;
    logic                  buffer_select;
    logic                  mode_select;
    logic [1:0]            channel_field;
    logic                  timer_trigger;
    logic                  four_trigger;
    logic [2:0]            time_sel;
    logic                  converter_status;

    // sequencer
    sadc_state_e           state;
    logic [3:0]            cnt;
    logic [3:0]            bit_idx;
    logic [SADC_RES_W-1:0] approximation_register;
    logic [1:0]            conv_count;
    logic [1:0]            trig_ch;
    logic [1:0]            cur_ch;
    logic [SADC_RES_W-1:0] result_register [SADC_NCH];

    // decode
    logic                  write_a;
    logic                  write_b;
    logic                  new_enable;
    logic                  new_timer;
    logic                  trig_hit;
    logic [1:0]            trig_idx;
    logic [1:0]            next_ch;
    logic [1:0]            dest;
    logic                  last_conv;
    logic [3:0]            settle_clks;
    logic [2:0]            rd_res;
    logic [2:0]            rd_high;
    logic                  ctl_write;
    logic                  store_now;
    logic                  start_done;
    logic                  sample_done;
    logic                  step_done;

    assign write_a = reg_write && (reg_addr == SADC_CTRL_A_ADDR);
    assign write_b = reg_write && (reg_addr == SADC_CTRL_B_ADDR);
    assign new_enable = write_a ? reg_wdata[SADC_A_ENABLE_BIT] : enable;
    assign new_timer  = write_b ? reg_wdata[SADC_B_TIMER_BIT] : timer_trigger;
    assign settle_clks = {1'b0, time_sel} + SADC_SETTLE_BASE;
    assign ctl_write   = write_a || write_b;
    assign store_now   = (state == SADC_STORE) && !ctl_write;
    assign start_done  = (cnt == SADC_START_CLKS - 4'h1);
    assign sample_done = (cnt == SADC_SAMPLE_CLKS - 4'h1);
    assign step_done   = (cnt == settle_clks - 4'h1);

    // trigger source: one match line, or any of four with lowest first
    always_comb begin
        trig_hit = 1'b0;
        trig_idx = 2'h0;
        if (!four_trigger) begin
            trig_hit = timer_match[0];
        end else begin
            for (int i = SADC_NCH - 1; i >= 0; i--) begin
                if (timer_match[i]) begin
                    trig_hit = 1'b1;                         // [R12]
                    trig_idx = i[1:0];
                end
            end
        end
    end

    // channel of the coming conversion
    always_comb begin
        if (mode_select) begin
            next_ch = channel_field;                         // [R11]
        end else if (timer_trigger && four_trigger) begin
            next_ch = trig_ch;                               // [R12]
        end else begin
            next_ch = conv_count;                            // [R23]
        end
    end

    // destination slot and end-of-run test
    always_comb begin
        if (mode_select && buffer_select) begin
            // 4-buffer runs fill the slots in order, whatever the channel
            dest      = conv_count;                          // [R22]
            last_conv = (conv_count == 2'h3);
        end else if (mode_select) begin
            dest      = cur_ch;                              // [R19]
            last_conv = 1'b1;                                // [R26]
        end else begin
            dest      = cur_ch;                              // [R23]
            last_conv = (conv_count == channel_field);       // [R11]
        end
    end

    // control register A
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable        <= SADC_CTRL_A_RESET[SADC_A_ENABLE_BIT];
            buffer_select <= SADC_CTRL_A_RESET[SADC_A_BUFFER_BIT];
            mode_select   <= SADC_CTRL_A_RESET[SADC_A_MODE_BIT];
            channel_field <= SADC_CTRL_A_RESET[SADC_A_CHAN_LSB +: 2];
        end else if (write_a) begin
            // status bit is not stored from the write  [R6]
            enable        <= reg_wdata[SADC_A_ENABLE_BIT];   // [R7] [R13]
            buffer_select <= reg_wdata[SADC_A_BUFFER_BIT];   // [R9]
            mode_select   <= reg_wdata[SADC_A_MODE_BIT];     // [R10]
            channel_field <= reg_wdata[SADC_A_CHAN_LSB +: 2];
        end
    end

    // control register B
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_trigger <= SADC_CTRL_B_RESET[SADC_B_TIMER_BIT];
            four_trigger  <= SADC_CTRL_B_RESET[SADC_B_FOUR_BIT];
            time_sel      <= SADC_CTRL_B_RESET[SADC_B_TIME_LSB +: 3];
        end else if (write_b) begin
            timer_trigger <= reg_wdata[SADC_B_TIMER_BIT];    // [R16]
            four_trigger  <= reg_wdata[SADC_B_FOUR_BIT];
            time_sel      <= reg_wdata[SADC_B_TIME_LSB +: 3];
        end
    end

    // conversion sequencer
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state                  <= SADC_IDLE;
            cnt                    <= 4'h0;
            bit_idx                <= 4'h0;
            approximation_register <= '0;
            conv_count             <= 2'h0;
            trig_ch                <= 2'h0;
            cur_ch                 <= 2'h0;
            converter_status       <= 1'b0;
            conversion_done_irq    <= 1'b0;
        end else begin
            conversion_done_irq <= 1'b0;
            if (ctl_write) begin
                // any control write drops the running conversion
                converter_status <= 1'b0;                    // [R5] [R16]
                conv_count       <= 2'h0;
                cnt              <= 4'h0;
                if (!new_enable) begin
                    state <= SADC_IDLE;                      // [R7]
                end else if (new_timer) begin
                    state <= SADC_WAIT;                      // [R13] [R15]
                end else begin
                    state <= SADC_START;                     // [R14]
                end
            end else begin
                unique case (state)
                    SADC_IDLE: begin
                        converter_status <= 1'b0;
                    end

                    SADC_WAIT: begin
                        // matches outside the wait state are not heard
                        if (trig_hit) begin
                            trig_ch <= trig_idx;             // [R12]
                            cnt     <= 4'h0;
                            state   <= SADC_START;           // [R24]
                        end
                    end

                    SADC_START: begin
                        if (start_done) begin
                            converter_status <= 1'b1;        // [R8] [R6]
                            cur_ch           <= next_ch;     // [R4]
                            cnt              <= 4'h0;
                            state            <= SADC_SAMPLE;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end

                    SADC_SAMPLE: begin
                        if (sample_done) begin
                            cnt     <= 4'h0;
                            bit_idx <= 4'(SADC_RES_W - 1);   // [R1]
                            approximation_register <= 10'h200;
                            state   <= SADC_CONVERT;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end

                    SADC_CONVERT: begin
                        if (step_done) begin
                            cnt <= 4'h0;
                            if (!comparator_high) begin
                                approximation_register[bit_idx]
                                    <= 1'b0;                 // [R25]
                            end
                            if (bit_idx == 4'h0) begin
                                state <= SADC_STORE;         // [R2]
                            end else begin
                                bit_idx <= bit_idx - 4'h1;   // [R1]
                                approximation_register[bit_idx - 4'h1]
                                    <= 1'b1;                 // [R25]
                            end
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end

                    SADC_STORE: begin
                        // timer runs go back to waiting after every result
                        cnt <= 4'h0;
                        if (last_conv) begin
                            conversion_done_irq <= 1'b1;     // [R21]
                            conv_count          <= 2'h0;
                        end else begin
                            conv_count <= conv_count + 2'h1;
                        end
                        if (timer_trigger) begin
                            converter_status <= 1'b0;
                            state            <= SADC_WAIT;   // [R24]
                        end else if (last_conv) begin
                            converter_status <= 1'b0;
                            state            <= SADC_IDLE;   // [R26]
                        end else begin
                            state <= SADC_START;             // [R23]
                        end
                    end

                    // only the two unused state codes land here
                    default: begin
                        converter_status <= 1'b0;
                        state            <= SADC_IDLE;
                    end
                endcase
            end
        end
    end

    // result slots carry no reset  [R3]
    always_ff @(posedge sys_clk) begin
        // a control write in the store cycle drops the result
        if (store_now) begin
            result_register[dest] <= approximation_register; // [R2] [R20]
        end
    end

    assign rd_res  = slot_hit(reg_addr, SADC_RESULT_BASE, SADC_RESULT_STEP);
    assign rd_high = slot_hit(reg_addr, SADC_HIGH_BASE, SADC_HIGH_STEP);

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            if (reg_addr == SADC_CTRL_A_ADDR) begin
                reg_rdata <= {8'h00, enable, converter_status,
                              buffer_select, mode_select, 2'b00,
                              channel_field};
            end else if (reg_addr == SADC_CTRL_B_ADDR) begin
                reg_rdata <= {8'h00, 2'b00, timer_trigger, four_trigger,
                              1'b0, time_sel};
            end else if (rd_res[2]) begin
                reg_rdata <= {6'h00,
                              result_register[rd_res[1:0]]}; // [R17] [R18]
            end else if (rd_high[2]) begin
                reg_rdata <= {8'h00,
                              result_register[rd_high[1:0]][9:2]};  // [R17]
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    assign channel_sel = cur_ch;                             // [R4]
    assign sample_hold = (state == SADC_SAMPLE);             // [R4]
    assign tap_code    = approximation_register;             // [R25]

endmodule // sadc_top
